// ===== design/amp_switch_ctrl.sv
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "amp_switch_defs.svh"

module amp_switch_ctrl
   import amp_switch_pkg::*;
#(
   parameter bit FULL_VARIANT = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic amp1_out_level,
   input wire logic amp2_out_level,
   output logic [1:0] amp_enable,
   output logic [1:0] out_pin_switch,
   output logic [1:0] cmp_route_switch,
   output logic [1:0] self_fb_switch,
   output logic [1:0] pos_pin_switch,
   output logic [1:0] neg_pin_switch,
   output logic [1:0] ref_low_switch,
   output logic [1:0] ref_mid_switch,
   output logic [1:0] ref_high_switch,
   output logic [1:0] cal_neg_switch,
   output logic [1:0] cal_pos_switch,
   output logic [1:0] cal_short_switch,
   output logic [4:0] amp1_trim_code,
   output logic [4:0] amp2_trim_code,
   output logic amp1_to_amp2_neg,
   output logic amp1_to_amp2_pos,
   output logic gain_net_enable,
   output logic [2:0] gain_code
);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic idx_valid(input logic [31:0] a);
      idx_valid = (a[31:5] == 27'h0) && (a[4:2] <= `OFS_AMP2_GAIN);
   endfunction

   function automatic logic [2:0] ref_decode(input logic [7:0] p);
      ref_sel_e s;
      s = p[`B_POS_PIN] ? REF_NONE : ref_sel_e'(p[`B_PSEL_HI:`B_PSEL_LO]);
      ref_decode = {s == REF_LOW, s == REF_MID, s == REF_HIGH};
   endfunction

   // Returns {short, pos, neg}; the lite variant has no calibration switches.
   function automatic logic [2:0] cal_decode(input logic [6:0] t);
      if (!FULL_VARIANT) begin
         cal_decode = 3'h0;
      end else if (!t[`B_MODE]) begin
         cal_decode = 3'b011;
      end else begin
         cal_decode = {1'b1, t[`B_REFSEL], !t[`B_REFSEL]};
      end
   endfunction

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [6:0] trim_q [2];
   byte_t path_q [2];
   logic [5:0] gain_q;
   logic [31:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic do_write;
   logic [2:0] wr_idx;
   logic [1:0] level;
   byte_t rd_d;

   assign level = {amp2_out_level, amp1_out_level};
   assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_idx = awaddr_q[4:2];

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   // Address and data are held until both have arrived, so either order works.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         awaddr_q <= 32'h0;
         wdata_q <= 8'h0;
         wstrb0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= idx_valid(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Only byte lane 0 carries register bits; upper lanes are ignored.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trim_q[0] <= `TRIM_RST;
         trim_q[1] <= `TRIM_RST;
         path_q[0] <= `PATH_RST;
         path_q[1] <= `PATH_RST;
         gain_q <= `GAIN_RST;
      end else if (do_write && wstrb0_q && idx_valid(awaddr_q)) begin
         case (wr_idx)
            `OFS_AMP1_TRIM: begin
               if (FULL_VARIANT) begin
                  trim_q[0] <= wdata_q[6:0];
               end
            end
            `OFS_AMP2_TRIM: begin
               if (FULL_VARIANT) begin
                  trim_q[1] <= wdata_q[6:0];
               end
            end
            `OFS_AMP1_PATH: path_q[0] <= wdata_q;
            `OFS_AMP2_PATH: path_q[1] <= wdata_q;
            `OFS_AMP2_GAIN: gain_q <= {wdata_q[7:6], wdata_q[3:0]};
            default: gain_q <= gain_q;
         endcase
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   always_comb begin
      case (s_axi_araddr[4:2])
         `OFS_AMP1_TRIM: rd_d = {level[0], FULL_VARIANT ? trim_q[0] : 7'h0};
         `OFS_AMP2_TRIM: rd_d = {level[1], FULL_VARIANT ? trim_q[1] : 7'h0};
         `OFS_AMP1_PATH: rd_d = path_q[0];
         `OFS_AMP2_PATH: rd_d = path_q[1];
         `OFS_AMP2_GAIN: rd_d = {gain_q[5:4], 2'h0, gain_q[3:0]};
         default: rd_d = 8'h0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= idx_valid(s_axi_araddr) ? {24'h0, rd_d} : 32'h0;
            s_axi_rresp <= idx_valid(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Switch decode
   // ----------------------------------------
   // Outputs are registered so the analog side never sees decode glitches,
   // at the cost of one cycle between a register change and the switch.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_enable <= 2'h0;
         out_pin_switch <= 2'h0;
         cmp_route_switch <= 2'h0;
         self_fb_switch <= 2'h0;
         pos_pin_switch <= 2'h0;
         neg_pin_switch <= 2'h0;
         ref_low_switch <= 2'h0;
         ref_mid_switch <= 2'h0;
         ref_high_switch <= 2'h0;
         cal_neg_switch <= 2'h0;
         cal_pos_switch <= 2'h0;
         cal_short_switch <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            amp_enable[i] <= path_q[i][`B_EN];
            out_pin_switch[i] <= path_q[i][`B_EN] && path_q[i][`B_OUT_EN];
            cmp_route_switch[i] <= path_q[i][`B_TO_CMP];
            self_fb_switch[i] <= path_q[i][`B_FB];
            pos_pin_switch[i] <= path_q[i][`B_POS_PIN];
            neg_pin_switch[i] <= path_q[i][`B_NEG_PIN];
            {ref_low_switch[i], ref_mid_switch[i], ref_high_switch[i]} <= ref_decode(path_q[i]);
            {cal_short_switch[i], cal_pos_switch[i], cal_neg_switch[i]} <= cal_decode(trim_q[i]);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp1_trim_code <= 5'h0;
         amp2_trim_code <= 5'h0;
         amp1_to_amp2_neg <= 1'b0;
         amp1_to_amp2_pos <= 1'b0;
         gain_net_enable <= 1'b0;
         gain_code <= 3'h0;
      end else begin
         amp1_trim_code <= FULL_VARIANT ? trim_q[0][4:0] : 5'h0;
         amp2_trim_code <= FULL_VARIANT ? trim_q[1][4:0] : 5'h0;
         amp1_to_amp2_neg <= gain_q[5];
         amp1_to_amp2_pos <= gain_q[4];
         gain_net_enable <= gain_q[`B_GAIN_EN];
         gain_code <= gain_q[2:0];
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_write_ready;
      do_write;
   endsequence

   sequence s_write_answered;
      s_axi_bvalid && s_axi_bready;
   endsequence

   sequence s_path1_hit;
      wstrb0_q && (wr_idx == `OFS_AMP1_PATH) && idx_valid(awaddr_q);
   endsequence

   a_write_answer: assert property (s_write_ready |=> s_axi_bvalid)
      else $error("write not answered next cycle");

   a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read upper bits not zero");

   a_gain_hole_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h10
      |=> s_axi_rdata[5:4] == 2'h0)
      else $error("gain register reserved bits not zero");

   a_level_bit: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0
      |=> s_axi_rdata[7] == $past(amp1_out_level))
      else $error("output level bit wrong");

   a_gain_follow: assert property (1'b1 |=> gain_code == $past(gain_q[2:0]))
      else $error("gain code not following register");

   a_link_follow: assert property (1'b1 |=> amp1_to_amp2_neg == $past(gain_q[5])
      && amp1_to_amp2_pos == $past(gain_q[4]))
      else $error("amp link switches wrong");

   a_gain_en_follow: assert property (1'b1 |=> gain_net_enable == $past(gain_q[`B_GAIN_EN]))
      else $error("gain network enable not following register");

   a_trim1_follow: assert property (1'b1 |=> amp1_trim_code == (FULL_VARIANT ? $past(trim_q[0][4:0]) : 5'h0))
      else $error("first trim code not following register");

   a_trim2_follow: assert property (1'b1 |=> amp2_trim_code == (FULL_VARIANT ? $past(trim_q[1][4:0]) : 5'h0))
      else $error("second trim code not following register");

   a_level2_bit: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h8
      |=> s_axi_rdata[7] == $past(amp2_out_level))
      else $error("second output level bit wrong");

   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");

   a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not released");

   a_path_write: assert property (s_write_ready ##0 s_path1_hit |=> path_q[0] == $past(wdata_q))
      else $error("path register write lost");

   a_strobe_off: assert property (s_write_ready ##0 !wstrb0_q
      |=> path_q[0] == $past(path_q[0]) && gain_q == $past(gain_q))
      else $error("write without byte strobe changed a register");

   a_bad_addr: assert property (s_write_ready ##0 !idx_valid(awaddr_q) |=> s_axi_bresp == `RESP_SLVERR)
      else $error("unmapped write not refused");

   a_resp_release: assert property (s_write_answered |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write answer not released");

   // ----------------------------------------
   // Per-amplifier switch checks
   // ----------------------------------------

   for (genvar g = 0; g < 2; g++) begin : g_chk
      a_out_forced: assert property (!path_q[g][`B_EN] |=> !out_pin_switch[g])
         else $error("output pin switch closed while disabled");

      a_ref_forced: assert property (path_q[g][`B_POS_PIN]
         |=> !ref_low_switch[g] && !ref_mid_switch[g] && !ref_high_switch[g])
         else $error("reference tap closed with pin connected");

      a_ref_high: assert property (path_q[g][5:3] == 3'b010 |=> ref_high_switch[g])
         else $error("high tap not closed");

      a_cal_mode: assert property (FULL_VARIANT && trim_q[g][`B_MODE]
         |=> cal_short_switch[g] && (cal_pos_switch[g] != cal_neg_switch[g]))
         else $error("offset mode switches wrong");

      a_cal_normal: assert property (FULL_VARIANT && !trim_q[g][`B_MODE]
         |=> !cal_short_switch[g] && cal_pos_switch[g] && cal_neg_switch[g])
         else $error("normal mode switches wrong");

      a_cmp_route: assert property (path_q[g][`B_TO_CMP] |=> cmp_route_switch[g])
         else $error("comparator route not closed");

      a_cmp_open: assert property (!path_q[g][`B_TO_CMP] |=> !cmp_route_switch[g])
         else $error("comparator route closed while off");

      a_enable_follow: assert property (1'b1 |=> amp_enable[g] == $past(path_q[g][`B_EN]))
         else $error("amplifier enable not following register");

      a_out_closed: assert property (path_q[g][`B_EN] && path_q[g][`B_OUT_EN] |=> out_pin_switch[g])
         else $error("output pin switch open while enabled");

      a_fb_follow: assert property (1'b1 |=> self_fb_switch[g] == $past(path_q[g][`B_FB]))
         else $error("feedback switch not following register");

      a_pos_pin_follow: assert property (1'b1 |=> pos_pin_switch[g] == $past(path_q[g][`B_POS_PIN]))
         else $error("non-inverting pin switch wrong");

      a_neg_pin_follow: assert property (1'b1 |=> neg_pin_switch[g] == $past(path_q[g][`B_NEG_PIN]))
         else $error("inverting pin switch wrong");

      a_ref_mid: assert property (path_q[g][5:3] == 3'b100 |=> ref_mid_switch[g])
         else $error("mid tap not closed");

      a_ref_low: assert property (path_q[g][5:3] == 3'b110 |=> ref_low_switch[g])
         else $error("low tap not closed");

      a_ref_none: assert property (path_q[g][5:3] == 3'b000
         |=> !ref_low_switch[g] && !ref_mid_switch[g] && !ref_high_switch[g])
         else $error("tap closed with no source selected");

      a_ref_single: assert property (1'b1 |=> $onehot0({ref_low_switch[g], ref_mid_switch[g], ref_high_switch[g]}))
         else $error("more than one reference tap closed");

      a_cal_ref_pick: assert property (FULL_VARIANT && trim_q[g][`B_MODE]
         |=> cal_pos_switch[g] == $past(trim_q[g][`B_REFSEL]))
         else $error("offset mode reference switch wrong");

      a_cal_short: assert property (FULL_VARIANT |=> cal_short_switch[g] == $past(trim_q[g][`B_MODE]))
         else $error("calibration short not following mode");
   end

endmodule // amp_switch_ctrl

// ===== dv/dual_amp_switch_control_test.sv
`timescale 1ns/100ps
`include "amp_switch_defs.svh"

module dual_amp_switch_control_test;
   typedef struct {logic rd; logic [1:0] resp; logic [31:0] data;} exp_s;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic amp1_out_level = 1'b0, amp2_out_level = 1'b0;
   logic [1:0] amp_enable, out_pin_switch, cmp_route_switch, self_fb_switch, pos_pin_switch, neg_pin_switch;
   logic [1:0] ref_low_switch, ref_mid_switch, ref_high_switch, cal_neg_switch, cal_pos_switch, cal_short_switch;
   logic [4:0] amp1_trim_code, amp2_trim_code;
   logic amp1_to_amp2_neg, amp1_to_amp2_pos, gain_net_enable;
   logic [2:0] gain_code;
   exp_s exp_q[$];
   exp_s e;
   int err_total = 0;
   int cmp_count = 0;
   logic [31:0] lf = 32'h1ff91a02;
   logic [7:0] path_s[2], trim_s[2], gain_s;

   always #2 clk = ~clk;

   amp_switch_ctrl #(.FULL_VARIANT(1'b1)) dut (.*);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Order: enable, out pin, cmp, feedback, pos pin, neg pin, low, mid, high, cal neg, cal pos, short.
   function automatic logic [11:0] sw_exp(input logic [7:0] p, input logic [7:0] t);
      logic [1:0] s;
      s = p[3] ? 2'b00 : p[5:4];
      return {p[0], p[0] & p[1], p[7], p[6], p[3], p[2], s == 2'h3, s == 2'h2, s == 2'h1,
         ~t[6] | ~t[5], ~t[6] | t[5], t[6]};
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] want, input string what);
      cmp_count++;
      if (got !== want) begin
         err_total++;
         $display("BAD %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // A bound on every wait keeps a stuck handshake from hanging the run.
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 40) begin
         err_total++;
         $display("BAD %0t: no bus answer", $time);
         final_report();
      end
   endtask

   // ----------------------------------------
   // Bus master
   // ----------------------------------------
   task automatic wr(input logic [2:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
      int n;
      logic done;
      n = 0;
      exp_q.push_back('{1'b0, r, 32'h0});
      s_axi_awaddr <= {27'h0, idx, 2'b00};
      s_axi_wdata <= {lf[31:8], d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         done = s_axi_bvalid;
      end while (!done);
   endtask

   task automatic rd(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] r);
      int n;
      logic done;
      n = 0;
      exp_q.push_back('{1'b1, r, {24'h0, d}});
      s_axi_araddr <= {27'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         done = s_axi_rvalid;
      end while (!done);
   endtask

   // Answers are compared against the oldest note taken by the driver.
   always @(posedge clk) begin
      if (!sys_rst && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
         if (exp_q.size() == 0) begin
            err_total++;
            $display("BAD %0t: unexpected answer", $time);
         end else begin
            e = exp_q.pop_front();
            chk(s_axi_rvalid ? {1'b1, s_axi_rresp, s_axi_rdata} : {1'b0, s_axi_bresp, 32'h0},
               {e.rd, e.resp, e.data}, "bus answer");
         end
      end
   end

   // Outputs are looked at one edge after the write answer, once they have settled.
   task automatic sw_check;
      logic [11:0] a;
      @(posedge clk);
      for (int i = 0; i < 2; i++) begin
         a = {amp_enable[i], out_pin_switch[i], cmp_route_switch[i], self_fb_switch[i], pos_pin_switch[i],
            neg_pin_switch[i], ref_low_switch[i], ref_mid_switch[i], ref_high_switch[i], cal_neg_switch[i],
            cal_pos_switch[i], cal_short_switch[i]};
         chk(a, sw_exp(path_s[i], trim_s[i]), "switches");
      end
      chk({amp1_trim_code, amp2_trim_code}, {trim_s[0][4:0], trim_s[1][4:0]}, "trim");
      chk({amp1_to_amp2_neg, amp1_to_amp2_pos, gain_net_enable, gain_code},
         {gain_s[7:6], gain_s[3:0]}, "gain");
   endtask

   task automatic set_all(input logic i, input logic [7:0] p, input logic [7:0] t, input logic [7:0] g);
      wr(i ? `OFS_AMP2_PATH : `OFS_AMP1_PATH, p, 4'h1, `RESP_OKAY);
      wr(i ? `OFS_AMP2_TRIM : `OFS_AMP1_TRIM, t, 4'hf, `RESP_OKAY);
      wr(`OFS_AMP2_GAIN, g, {lf[29:27], 1'b1}, `RESP_OKAY);
      path_s[i] = p;
      trim_s[i] = t;
      gain_s = g;
      sw_check();
      rd(i ? `OFS_AMP2_TRIM : `OFS_AMP1_TRIM, {i ? amp2_out_level : amp1_out_level, t[6:0]}, `RESP_OKAY);
      rd(i ? `OFS_AMP2_PATH : `OFS_AMP1_PATH, p, `RESP_OKAY);
      rd(`OFS_AMP2_GAIN, g & 8'hcf, `RESP_OKAY);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      path_s = '{`PATH_RST, `PATH_RST};
      trim_s = '{{1'b0, `TRIM_RST}, {1'b0, `TRIM_RST}};
      gain_s = 8'h00;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      sw_check();
      rd(`OFS_AMP1_TRIM, {1'b0, `TRIM_RST}, `RESP_OKAY);
      rd(`OFS_AMP2_TRIM, {1'b0, `TRIM_RST}, `RESP_OKAY);
      rd(`OFS_AMP1_PATH, `PATH_RST, `RESP_OKAY);
      rd(`OFS_AMP2_PATH, `PATH_RST, `RESP_OKAY);
      rd(`OFS_AMP2_GAIN, 8'h00, `RESP_OKAY);
      $display("reset values test done");
      for (int k = 0; k < 16; k++) begin
         set_all(k[3], {k[1], k[2], k[1:0], k[2], 1'b1, k[0], 1'b1},
            {1'b1, k[0], k[1], 5'(k)}, {k[0], k[1], 2'b11, 1'b1, k[2:0]});
      end
      $display("code table test done");
      for (int n = 0; n < 24; n++) begin
         lf = nxt(lf);
         amp1_out_level <= lf[24];
         amp2_out_level <= lf[25];
         set_all(lf[26], lf[7:0], lf[15:8], lf[23:16]);
      end
      $display("random settings test done");
      // The bench plays the amplifier: its output flips once the trim reaches a random threshold.
      for (int i = 0; i < 2; i++) begin
         lf = nxt(lf);
         amp1_out_level <= 1'b0;
         amp2_out_level <= 1'b0;
         set_all(i[0], path_s[i], 8'h40, gain_s);
         set_all(i[0], path_s[i], 8'h60, gain_s);
         for (int c = 0; c < 32 && !(i ? amp2_out_level : amp1_out_level); c++) begin
            if (c == lf[4:0]) begin
               if (i) amp2_out_level <= 1'b1;
               else amp1_out_level <= 1'b1;
            end
            set_all(i[0], path_s[i], 8'h60 | 8'(c), gain_s);
         end
         chk(i ? amp2_out_level : amp1_out_level, 1'b1, "calibration end");
         set_all(i[0], path_s[i], trim_s[i] & 8'h1f, gain_s);
      end
      $display("calibration test done");
      wr(`OFS_AMP1_PATH, 8'hff, 4'he, `RESP_OKAY);
      wr(3'h5, 8'hff, 4'hf, `RESP_SLVERR);
      sw_check();
      rd(`OFS_AMP1_PATH, path_s[0], `RESP_OKAY);
      rd(3'h5, 8'h00, `RESP_SLVERR);
      $display("refused access test done");
      final_report();
   end
endmodule // dual_amp_switch_control_test

// ===== inc/amp_switch_defs.svh
`ifndef AMP_SWITCH_DEFS_SVH
`define AMP_SWITCH_DEFS_SVH

// ----------------------------------------
// Register word indexes (address bits 4:2)
// ----------------------------------------
`define OFS_AMP1_TRIM 3'h0
`define OFS_AMP1_PATH 3'h1
`define OFS_AMP2_TRIM 3'h2
`define OFS_AMP2_PATH 3'h3
`define OFS_AMP2_GAIN 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_LEVEL 7
`define B_MODE 6
`define B_REFSEL 5
`define B_TO_CMP 7
`define B_FB 6
`define B_PSEL_HI 5
`define B_PSEL_LO 4
`define B_POS_PIN 3
`define B_NEG_PIN 2
`define B_OUT_EN 1
`define B_EN 0
`define B_L_NEG 7
`define B_L_POS 6
`define B_GAIN_EN 3

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define TRIM_RST 7'h10
`define PATH_RST 8'h0c
`define GAIN_RST 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== inc/amp_switch_pkg.sv
package amp_switch_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      REF_NONE = 2'h0,
      REF_HIGH = 2'h1,
      REF_MID = 2'h2,
      REF_LOW = 2'h3
   } ref_sel_e;
endpackage
